// ===== rtl/memory_bank_controller.sv
// Chip-select bank logic with DRAM page compare, cycle timing and refresh
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Refresh period is (count field + 1) times sixteen system clocks.
// - Page size code selects compared address lines; 16-bit ports compare one more.
// - Delayed-write bit shifts column strobe one clock on page-hit writes.
// - Write lengthening applies to internal, external 030-style and external 040-style masters alike.
// - External 040 SRAM cycle lasts length+2, or length+3 with start-sync.
// - Parity is active on cycles ended by external acknowledge until the acknowledge is seen.
// - Early select negation works regardless of the synchronous-mode bit.
// - Burst inhibit asserted on bank accesses when burst-ack option is zero.
// - First bank option bits 3 and 2 reset from the configuration pins.
// - External 040 masters are not served while the device is bus master.
module memory_bank_controller
    import memory_bank_pkg::*;
#(
    parameter int NUM_BANKS = 4,
    parameter int COUNT_W   = GLB_COUNT_W
)
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [31:0]          mem_addr,
    input  wire logic                 mem_strobe_n,
    input  wire logic                 mem_write,
    input  wire logic [1:0]           mem_source,
    input  wire logic                 ext_ack_n,
    input  wire logic                 device_is_master,
    input  wire logic [1:0]           config_strap,
    output logic [NUM_BANKS-1:0]      chip_select_n,
    output logic                      row_strobe_n,
    output logic                      column_strobe_n,
    output logic                      transfer_burst_inhibit_n,
    output logic                      cycle_done,
    output logic                      parity_active,
    output logic                      refresh_request
);
    localparam int SYNC_W = 32 + 1 + 1 + 2 + 1 + 1 + 2;
    localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
    // Address settles before the strobe falls, so one bundle sync is safe
    logic [SYNC_W-1:0] sync_stage1;
    logic [SYNC_W-1:0] sync_stage2;
    logic [31:0]       s_addr;
    logic              s_strobe;
    logic              s_write;
    source_t           s_source;
    logic              s_ext_ack;
    logic              s_master;
    logic [1:0]        s_strap;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_stage1 <= '0;
            sync_stage2 <= '0;
        end
        else
        begin
            sync_stage1 <= {mem_addr, ~mem_strobe_n, mem_write, mem_source,
                            ~ext_ack_n, device_is_master, config_strap};
            sync_stage2 <= sync_stage1;
        end
    end
    assign {s_addr, s_strobe, s_write} = sync_stage2[SYNC_W-1:SYNC_W-34];
    assign s_source  = source_t'(sync_stage2[5:4]);
    assign s_ext_ack = sync_stage2[3];
    assign s_master  = sync_stage2[2];
    assign s_strap   = sync_stage2[1:0];
    logic [31:0]  global_mem;
    logic [31:0]  bank_base [NUM_BANKS];
    logic [31:0]  bank_option [NUM_BANKS];
    logic [1:0]   strap_wait;
    logic [1:0]   strap_value;
    logic [7:0]   refresh_events;
    wire apb_setup = psel && !penable;
    wire apb_write = psel && penable && pwrite;
    function automatic logic [25:0] page_mask(input logic [2:0] code, input logic port16);
        int low;
        logic [25:0] m;
        low = PAGE_BASE_LOW + ((int'(code) + 1) / 2) - int'(port16);
        for (int i = 0; i <= PAGE_ADDR_TOP; i++)
            m[i] = (i >= low);
        return m;
    endfunction
    function automatic logic bank_match(input logic [31:0] addr, input logic [31:0] base,
                                        input logic [31:0] opt);
        return base[BASE_VALID_BIT] &&
               (((addr[31:16] ^ base[31:16]) & opt[31:OPT_MASK_LSB]) == 16'h0000);
    endfunction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            global_mem <= GLOBAL_RESET;
        else if (apb_write && paddr == ADDR_GLOBAL)
            global_mem <= {21'h000000, pwdata[GLB_PAGE_LSB +: GLB_PAGE_W],
                           pwdata[GLB_COUNT_LSB +: GLB_COUNT_W]};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                bank_base[b]   <= BASE_RESET;
                bank_option[b] <= OPTION_RESET;
            end
            strap_wait  <= '0;
            strap_value <= '0;
        end
        else
        begin
            if (strap_wait != 2'(STRAP_SETTLE))
            begin
                strap_wait <= strap_wait + 1'b1;
                if (strap_wait == 2'(STRAP_SETTLE - 1))
                begin
                    bank_option[0][OPT_STRAP_LSB +: 2] <= s_strap;
                    strap_value                        <= s_strap;
                end
            end
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                if (apb_write && paddr == ADDR_BANK_FIRST + 8'(b) * BANK_STRIDE)
                    bank_base[b] <= {pwdata[31:BASE_ADDR_LSB], 15'h0000, pwdata[BASE_VALID_BIT]};
                if (apb_write && paddr == ADDR_BANK_FIRST + 8'(b) * BANK_STRIDE + BANK_OPT_OFFSET)
                    bank_option[b] <= {pwdata[31:OPT_MASK_LSB], 3'h0, pwdata[OPT_SYNC_MODE:0]};
            end
        end
    end
    refresh_if #(.COUNT_W(COUNT_W)) rif ();
    assign rif.reload_count = global_mem[GLB_COUNT_LSB +: COUNT_W];
    refresh_timer #(.COUNT_W(COUNT_W)) u_refresh_timer
    (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif)
    );
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refresh_request <= 1'b0;
            refresh_events  <= '0;
        end
        else
        begin
            refresh_request <= rif.expire;
            if (rif.expire)
                refresh_events <= refresh_events + 1'b1;
        end
    end
    logic              any_hit;
    logic [BANK_W-1:0] hit_bank;
    always_comb
    begin
        any_hit  = 1'b0;
        hit_bank = '0;
        for (int b = NUM_BANKS - 1; b >= 0; b--)
        begin
            if (bank_match(s_addr, bank_base[b], bank_option[b]))
            begin
                any_hit  = 1'b1;
                hit_bank = BANK_W'(b);
            end
        end
    end
    cycle_state_t      state;
    logic [4:0]        elapsed;
    logic [4:0]        cur_len;
    logic              cur_delay;
    logic              cur_dram;
    logic              cur_040;
    logic              ext_terminated;
    logic [BANK_W-1:0] cur_bank;
    logic [25:0]       open_row;
    logic [BANK_W-1:0] open_bank;
    logic              open_valid;
    wire [31:0] hit_opt  = bank_option[hit_bank];
    wire        hit_dram = hit_opt[OPT_IS_DRAM];
    wire [25:0] hit_mask = page_mask(global_mem[GLB_PAGE_LSB +: GLB_PAGE_W], hit_opt[OPT_PORT16]);
    wire page_hit = hit_dram && hit_opt[OPT_PAGE_MODE] && open_valid &&
                    open_bank == hit_bank && ((s_addr[25:0] ^ open_row) & hit_mask) == '0;
    wire source_ok = !(s_source == SRC_EXT_040 && s_master);
    wire start     = state == ST_IDLE && s_strobe && any_hit && source_ok;
    wire delay_wr  = hit_opt[OPT_DELAY_WRITE] && page_hit && s_write;
    wire sync_add  = !hit_dram && s_source == SRC_EXT_040 && hit_opt[OPT_START_SYNC];
    wire [4:0] start_len = 5'(hit_opt[OPT_CYCLE_LSB +: OPT_CYCLE_W]) + CYCLE_EXTRA
                           + (sync_add ? START_SYNC_EXTRA : 5'h00)
                           + (delay_wr ? DELAY_WRITE_EXTRA : 5'h00);
    wire last      = state == ST_RUN && elapsed == cur_len - 5'h01;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state          <= ST_IDLE;
            elapsed        <= '0;
            cur_len        <= '0;
            cur_delay      <= 1'b0;
            cur_dram       <= 1'b0;
            cur_040        <= 1'b0;
            cur_bank       <= '0;
            ext_terminated <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    elapsed <= '0;
                    if (start)
                    begin
                        state          <= ST_RUN;
                        cur_len        <= start_len;
                        cur_delay      <= delay_wr;
                        cur_dram       <= hit_dram;
                        cur_040        <= s_source == SRC_EXT_040;
                        cur_bank       <= hit_bank;
                        ext_terminated <= 1'b0;
                    end
                end
                ST_RUN:
                begin
                    elapsed <= elapsed + 5'h01;
                    if (s_ext_ack)
                    begin
                        state          <= ST_HOLD;
                        ext_terminated <= 1'b1;
                    end
                    else if (last)
                        state <= ST_HOLD;
                end
                ST_HOLD:
                    if (!s_strobe)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            open_row   <= '0;
            open_bank  <= '0;
            open_valid <= 1'b0;
        end
        else if (rif.expire)
            open_valid <= 1'b0;
        else if (start && hit_dram)
        begin
            open_row   <= s_addr[25:0];
            open_bank  <= hit_bank;
            open_valid <= hit_opt[OPT_PAGE_MODE];
        end
    end
    wire        running = state == ST_RUN && !s_ext_ack;
    wire [31:0] cur_opt = bank_option[cur_bank];
    wire [4:0]  cas_on  = 5'h01 + (cur_delay ? DELAY_WRITE_EXTRA : 5'h00);
    wire early_neg = cur_040 && cur_opt[OPT_EARLY_NEG] && last;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chip_select_n            <= '1;
            row_strobe_n             <= 1'b1;
            column_strobe_n          <= 1'b1;
            transfer_burst_inhibit_n <= 1'b1;
            cycle_done               <= 1'b0;
            parity_active            <= 1'b0;
        end
        else
        begin
            for (int b = 0; b < NUM_BANKS; b++)
                chip_select_n[b] <= !(running && cur_bank == BANK_W'(b) && !early_neg);
            row_strobe_n    <= !(running && cur_dram);
            column_strobe_n <= !(running && cur_dram && elapsed >= cas_on &&
                                 elapsed < cur_len);
            transfer_burst_inhibit_n <= !(running && !cur_opt[OPT_BURST_ACK]);
            cycle_done      <= last && !s_ext_ack;
            parity_active   <= running && cur_opt[OPT_PARITY_EN] && !ext_terminated;
        end
    end
    logic [31:0] read_word;
    logic        read_err;
    always_comb
    begin
        read_word = 32'h0000_0000;
        read_err  = 1'b1;
        if (paddr == ADDR_GLOBAL)
        begin
            read_word = global_mem;
            read_err  = 1'b0;
        end
        else if (paddr == ADDR_STATUS)
        begin
            read_word = {16'h0000, refresh_events, 3'h0, ext_terminated,
                         strap_value, open_valid, state != ST_IDLE};
            read_err  = 1'b0;
        end
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            if (paddr == ADDR_BANK_FIRST + 8'(b) * BANK_STRIDE)
            begin
                read_word = bank_base[b];
                read_err  = 1'b0;
            end
            if (paddr == ADDR_BANK_FIRST + 8'(b) * BANK_STRIDE + BANK_OPT_OFFSET)
            begin
                read_word = bank_option[b];
                read_err  = 1'b0;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (apb_setup)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : read_word;
                pslverr <= read_err;
            end
        end
    end
endmodule // memory_bank_controller
`default_nettype wire

// ===== rtl/memory_bank_pkg.sv
// Constants, register map and types for the memory bank controller
package memory_bank_pkg;

    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_GLOBAL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_BANK_FIRST = 8'h10;
    localparam logic [7:0] BANK_STRIDE     = 8'h08;
    localparam logic [7:0] BANK_OPT_OFFSET = 8'h04;

    // Global memory register fields
    localparam int GLB_COUNT_LSB = 0;
    localparam int GLB_COUNT_W   = 8;
    localparam int GLB_PAGE_LSB  = 8;
    localparam int GLB_PAGE_W    = 3;

    // Bank base register fields
    localparam int BASE_VALID_BIT = 0;
    localparam int BASE_ADDR_LSB  = 16;

    // Bank option register fields
    localparam int OPT_BURST_ACK   = 0;
    localparam int OPT_EARLY_NEG   = 1;
    localparam int OPT_PORT16      = 2;
    localparam int OPT_START_SYNC  = 3;
    localparam int OPT_DELAY_WRITE = 4;
    localparam int OPT_PAGE_MODE   = 5;
    localparam int OPT_CYCLE_LSB   = 6;
    localparam int OPT_CYCLE_W     = 4;
    localparam int OPT_IS_DRAM     = 10;
    localparam int OPT_PARITY_EN   = 11;
    localparam int OPT_SYNC_MODE   = 12;
    localparam int OPT_MASK_LSB    = 16;
    localparam int OPT_STRAP_LSB   = 2;

    // Status register fields
    localparam int STS_BUSY       = 0;
    localparam int STS_PAGE_OPEN  = 1;
    localparam int STS_STRAP_LSB  = 2;
    localparam int STS_EXT_TERM   = 4;
    localparam int STS_REFRESH_LSB = 8;

    // Reset values
    localparam logic [31:0] GLOBAL_RESET = 32'h0000_0017;
    localparam logic [31:0] BASE_RESET   = 32'h0000_0000;
    localparam logic [31:0] OPTION_RESET = 32'h0000_03c1;

    // Timing
    localparam int          REFRESH_PRESCALE  = 16;
    localparam logic [4:0]  CYCLE_EXTRA       = 5'h02;
    localparam logic [4:0]  START_SYNC_EXTRA  = 5'h01;
    localparam logic [4:0]  DELAY_WRITE_EXTRA = 5'h01;
    localparam int          STRAP_SETTLE      = 3;

    // Page compare
    localparam int PAGE_BASE_LOW = 10;
    localparam int PAGE_ADDR_TOP = 25;

    typedef enum logic [1:0]
    {
        SRC_INTERNAL = 2'h0,
        SRC_EXT_030  = 2'h1,
        SRC_EXT_040  = 2'h2
    } source_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b11
    } cycle_state_t;

endpackage

// ===== rtl/refresh_if.sv
// Link between the controller and its refresh timer
`timescale 1ns/1ps
`default_nettype none
interface refresh_if #(parameter int COUNT_W = 8);
    logic [COUNT_W-1:0] reload_count;
    logic               expire;

    modport timer (input reload_count, output expire);
    modport user  (output reload_count, input expire);
endinterface
`default_nettype wire

// ===== rtl/refresh_timer.sv
// Refresh period timer
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
    import memory_bank_pkg::*;
#(
    parameter int COUNT_W = 8
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    refresh_if.timer  rif
);
    localparam int          PRE_W    = $clog2(REFRESH_PRESCALE);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(REFRESH_PRESCALE - 1);

    logic [PRE_W-1:0]   prescale;
    logic               tick;
    logic [COUNT_W-1:0] remaining;

    // One pulse every sixteen clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescale <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick     <= (prescale == PRE_LAST);
            prescale <= prescale + 1'b1;
        end
    end

    // Count+1 ticks per period; a new count takes effect at the next reload
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remaining  <= '0;
            rif.expire <= 1'b0;
        end
        else
        begin
            rif.expire <= 1'b0;
            if (tick)
            begin
                if (remaining == '0)
                begin
                    remaining  <= rif.reload_count;
                    rif.expire <= 1'b1;
                end
                else
                begin
                    remaining <= remaining - 1'b1;
                end
            end
        end
    end
endmodule // refresh_timer
`default_nettype wire

// ===== tb/memory_bank_chk.sv
// Port-level assertions for the memory bank controller
`timescale 1ns/1ps
`default_nettype none
module memory_bank_chk
    import memory_bank_pkg::*;
#(
    parameter int NUM_BANKS = 4
)
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 mem_write,
    input wire logic [1:0]           mem_source,
    input wire logic                 ext_ack_n,
    input wire logic                 device_is_master,
    input wire logic [NUM_BANKS-1:0] chip_select_n,
    input wire logic                 row_strobe_n,
    input wire logic                 column_strobe_n,
    input wire logic                 transfer_burst_inhibit_n,
    input wire logic                 cycle_done,
    input wire logic                 parity_active,
    input wire logic                 refresh_request
);
    logic [31:0] opt0;
    logic [5:0]  run;
    wire  [5:0]  cycle_length_field = 6'(opt0[9:6]);
    // Bank 0 option shadow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opt0 <= OPTION_RESET;
        else if (psel && penable && pwrite && paddr == ADDR_BANK_FIRST + BANK_OPT_OFFSET)
            opt0 <= pwdata;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run <= 6'h00;
        else
            run <= chip_select_n[0] ? 6'h00 : run + 6'h01;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_apb_ready; psel && !penable |=> pready; endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready in access phase");
    property p_refresh; refresh_request |=> !refresh_request [*8]; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh pulse too long");
    property p_done; cycle_done |=> !cycle_done; endproperty
    a_done: assert property (p_done) else $error("done pulse too long");
    property p_burst; !chip_select_n[0] |-> transfer_burst_inhibit_n == opt0[0]; endproperty
    a_burst: assert property (p_burst) else $error("burst inhibit wrong");
    property p_parity; !chip_select_n[0] && !opt0[11] |-> !parity_active; endproperty
    a_parity: assert property (p_parity) else $error("parity without enable");
    property p_cas; opt0[10] && $fell(chip_select_n[0]) |-> column_strobe_n && !row_strobe_n;
    endproperty
    a_cas: assert property (p_cas) else $error("dram strobes wrong");
    property p_ext_end;
        $fell(ext_ack_n) && !chip_select_n[0] |-> ##[1:5] (chip_select_n[0] && !cycle_done);
    endproperty
    a_ext_end: assert property (p_ext_end) else $error("external end wrong");
    property p_len_040;
        cycle_done && mem_source == SRC_EXT_040 && !opt0[10] && !opt0[1]
            |-> run + 6'h01 == cycle_length_field + 6'h02 + 6'(opt0[3]);
    endproperty
    a_len_040: assert property (p_len_040) else $error("ext cycle length wrong");
    property p_len_early;
        cycle_done && mem_source == SRC_EXT_040 && opt0[1]
            |-> run == cycle_length_field + 6'h01 + 6'(opt0[3]);
    endproperty
    a_len_early: assert property (p_len_early) else $error("early negate wrong");
    property p_len_dram;
        cycle_done && opt0[10] && !(mem_write && opt0[4]) |-> run + 6'h01 == cycle_length_field + 6'h02;
    endproperty
    a_len_dram: assert property (p_len_dram) else $error("dram length wrong");
    property p_refuse; (mem_source == SRC_EXT_040 && device_is_master) [*4] |-> &chip_select_n;
    endproperty
    a_refuse: assert property (p_refuse) else $error("ext master served");
    c_ext_end: cover property ($fell(ext_ack_n));
    c_refused: cover property (device_is_master && mem_source == SRC_EXT_040);
    c_delayed: cover property (cycle_done && mem_write && opt0[4]);
endmodule // memory_bank_chk

bind memory_bank_controller memory_bank_chk #(.NUM_BANKS(NUM_BANKS)) i_chk (.*);
`default_nettype wire

// ===== tb/mem_bank_model.sv
// Memory bank model: answers with an external acknowledge on command
`timescale 1ns/1ps
`default_nettype none
module mem_bank_model
#(
    parameter int NUM_BANKS = 4
)
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [NUM_BANKS-1:0] chip_select_n,
    input  wire logic                 ack_cmd,
    output logic                      ext_ack_n
);
    logic [1:0] held;

    // Pulled-up acknowledge reads high while deselected
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held      <= 2'h0;
            ext_ack_n <= 1'b1;
        end
        else if (&chip_select_n)
        begin
            held      <= 2'h0;
            ext_ack_n <= 1'b1;
        end
        else
        begin
            held <= held + 2'(held != 2'h3);
            if (ack_cmd && held == 2'h2)
                ext_ack_n <= 1'b0;
        end
    end
endmodule // mem_bank_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the memory bank controller
`timescale 1ns/1ps
`default_nettype none
module testbench
    import memory_bank_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ack_cmd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mem_addr, a;
    logic        mem_strobe_n, mem_write, ext_ack_n, device_is_master, cycle_done;
    logic [1:0]  mem_source, config_strap;
    logic [3:0]  chip_select_n;
    logic        row_strobe_n, column_strobe_n, transfer_burst_inhibit_n, parity_active;
    logic        refresh_request, tss, en;
    logic [64:0] e;
    logic [64:0] rdq[$];
    int          lenq[$];
    int          gapq[$];
    int          mismatches, num_checks, seed, run, len, gap, n, tc;

    memory_bank_controller i_dut (.*);
    mem_bank_model i_mem (.*);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_until(input int what, input logic lvl);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((what ? refresh_request : &chip_select_n) !== lvl && n < 5000);
        if (n >= 5000)
        begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                       input logic [64:0] x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        if (!wr)
            rdq.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic mem_cycle(input logic [1:0] src, input logic wr, input logic [31:0] ad,
                             input int exp);
        if (exp >= 0)
            lenq.push_back(exp);
        mem_source <= src;
        mem_write <= wr;
        mem_addr <= ad;
        mem_strobe_n <= 1'b0;
        wait_until(0, 1'b0);
        wait_until(0, 1'b1);
        mem_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [31:0] opt(input int t, input logic dram, dw, ss, early);
        return {16'hffff, 4'h0, early, dram, 4'(t), dram, dw, ss, 1'b0, early, early};
    endfunction

    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && rdq.size() > 0)
        begin
            e = rdq.pop_front();
            chk("register read", {e[64], e[63:32]}, {pslverr, prdata & e[31:0]});
        end
        if (!(&chip_select_n))
            run++;
        else if (run > 0)
        begin
            len = run;
            run = 0;
        end
        if (cycle_done)
            chk("select length", 33'(lenq.size() ? lenq.pop_front() : -1),
                33'(&chip_select_n ? len : run));
        gap++;
        if (refresh_request)
        begin
            if (gapq.size() > 0)
                chk("refresh gap", 33'(gapq.pop_front()), 33'(gap));
            gap = 0;
        end
    end

    initial
    begin
        seed = 54;
        {psel, penable, pwrite, paddr, pwdata, mem_addr, mem_write, mem_source} = '0;
        {ack_cmd, device_is_master, presetn} = '0;
        mem_strobe_n = 1'b1;
        config_strap = 2'($random(seed));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(0, ADDR_GLOBAL, 0, {1'b0, GLOBAL_RESET, 32'hffffffff});
        apb(0, 8'h14, 0, {1'b0, (OPTION_RESET & ~32'hc) | (32'(config_strap) << 2), ~32'h0});
        apb(0, ADDR_STATUS, 0, {1'b0, 32'(config_strap) << 2, 32'hc});
        apb(0, 8'hfc, 0, {1'b1, 32'h0, 32'hffffffff});
        for (tc = 0; tc <= 2; tc += 2)
        begin
            apb(1, ADDR_GLOBAL, 32'(tc), 0);
            wait_until(1, 1'b1);
            wait_until(1, 1'b1);
            @(posedge pclk);
            gapq.push_back((tc + 1) * 16);
            wait_until(1, 1'b1);
        end
        // Long period keeps refresh from closing pages mid-test
        apb(1, ADDR_GLOBAL, 32'hff, 0);
        wait_until(1, 1'b1);
        apb(1, ADDR_BANK_FIRST, 32'h1, 0);
        for (int i = 0; i < 8; i++)
        begin
            tc = i[0] ? 15 : 0;
            tss = i[1];
            en = i[2];
            apb(1, 8'h14, opt(tc, 0, 0, tss, en), 0);
            mem_cycle(SRC_EXT_040, 1'($random(seed)), 32'($random(seed)) & 32'h3fc,
                      tc + 2 + tss - en);
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1, 8'h14, opt(i[1], 1, i[0] | !i[1], 0, 0), 0);
            a = 32'($random(seed)) & 32'h3fc;
            mem_cycle({1'b0, i[1]}, 0, a, 2 + i[1]);
            mem_cycle({1'b0, i[1]}, 1, a, 2 + i[1] + (i[0] | !i[1]));
            mem_cycle({1'b0, i[1]}, 1, a ^ 32'h400, 2 + i[1]);
        end
        apb(1, 8'h14, opt(15, 0, 0, 0, 1) & ~32'h2, 0);
        ack_cmd <= 1'b1;
        mem_cycle(SRC_INTERNAL, 0, 32'h0, -1);
        ack_cmd <= 1'b0;
        apb(0, ADDR_STATUS, 0, {1'b0, 32'h10, 32'h10});
        device_is_master <= 1'b1;
        mem_source <= SRC_EXT_040;
        mem_strobe_n <= 1'b0;
        run = 0;
        n = 0;
        repeat (12)
        begin
            @(posedge pclk);
            n += int'(!(&chip_select_n));
        end
        chk("refused selects", 33'h0, 33'(n));
        mem_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        test_done();
    end
endmodule // testbench
`default_nettype wire
